/* hw/qps_pkg.sv */
// Package for the QoS packet classifier and scheduler.
// Assumes one APB clock domain and 32-bit APB data.
package qps_pkg;
    // APB register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_DEFPRI = 8'h04;
    localparam logic [7:0] OFS_QSIZE  = 8'h08;
    localparam logic [7:0] OFS_TXLEN  = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_RSEL   = 8'h14;
    localparam logic [7:0] OFS_RSIP   = 8'h18;
    localparam logic [7:0] OFS_RSMK   = 8'h1C;
    localparam logic [7:0] OFS_RDIP   = 8'h20;
    localparam logic [7:0] OFS_RDMK   = 8'h24;
    localparam logic [7:0] OFS_RPORT  = 8'h28;
    localparam logic [7:0] OFS_RCFG   = 8'h2C;
    // Control bit positions
    localparam int CTRL_QOS = 0;
    localparam int CTRL_OPT = 1;
    localparam int CTRL_NOM = 2;
    localparam int CTRL_RTD = 3;
    // Reset values; levels coded 0..7 for level 1..8
    localparam logic [2:0] DEFPRI_RST = 3'h7;
    localparam logic [4:0] QSIZE_RST  = 5'h05;
    localparam logic [4:0] QSIZE_MIN  = 5'h02;
    localparam logic [4:0] QSIZE_MAX  = 5'h1F;
    localparam logic [3:0] TXLEN_RST  = 4'h4;
    localparam logic [3:0] QOS_TXB    = 4'h2;
    localparam int         NLVL       = 8;
    localparam int         QDEP       = 32;
    // Fixed DiffServ byte of internal time-sync packets
    localparam logic [7:0] NTP_DS     = 8'hB8;
    // Protocol numbers
    localparam logic [7:0] PN_ICMP = 8'h01;
    localparam logic [7:0] PN_TCP  = 8'h06;
    localparam logic [7:0] PN_UDP  = 8'h11;
    localparam logic [7:0] PN_GRE  = 8'h2F;
    localparam logic [7:0] PN_ESP  = 8'h32;

    typedef enum logic [2:0] {
        PS_ANY = 3'h0, PS_ICMP = 3'h1, PS_UDP = 3'h2,
        PS_TCP = 3'h3, PS_GRE = 3'h4, PS_ESP = 3'h5
    } qps_proto_e;
    typedef enum logic [1:0] {DS_OFF = 2'h0, DS_CP = 2'h1, DS_PREC = 2'h2} qps_dsm_e;
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SCAN = 2'b01, ST_PUSH = 2'b11} qps_st_e;

    // Packet descriptor
    typedef struct packed {
        logic [7:0]  proto;
        logic [31:0] sip;
        logic [31:0] dip;
        logic [15:0] sport;
        logic [15:0] dport;
        logic [7:0]  ds;
        logic        ntp;
        logic        radio;
    } qps_pkt_s;

    // diffserv_match_settings live in dsm/dsv
    typedef struct packed {
        logic [31:0] sip;
        logic [31:0] smk;
        logic [31:0] dip;
        logic [31:0] dmk;
        logic [15:0] sport;
        logic [15:0] dport;
        logic [2:0]  proto;
        logic [5:0]  spfx;
        logic [5:0]  dpfx;
        logic [1:0]  dsm;
        logic [5:0]  dsv;
        logic [2:0]  prio;
        logic        act;
    } qps_rule_s;
endpackage

/* hw/qps_top.sv */
// QoS classifier, eight-level fair queues and radio transmit buffer.
// Assumes synchronous packet handshakes and an APB master on pclk.
// Overview of operation
// - Eight priority levels, level 1 highest
// - Strict priority dispatch, higher levels first
// - Full level queue drops packet, no counting
// - Transmit buffer two packets while QoS on
// - Fair subqueues per level, bounded total
// - Unmatched packets take default, reset level 8
// - Queue size 2 to 31, reset 5
// - All specified fields must match
// - First matching rule in order wins
// - At most 64 active rules
// - Protocol select any/ICMP/UDP/TCP/GRE/ESP
// - Source address prefix and mask compare
// - Source port only for TCP/UDP
// - Destination matched like source
// - Code-point mode uses six top bits
// - Precedence mode three top bits; off ignores
// - Rule priority 1 to 8, reset 1
// - Inactive rules are skipped
// - Only radio-bound packets are queued
// - QoS, optimisation, nomadic mutually exclusive
// - Radio-bound time-sync packets carry DiffServ 0xB8; bypass leaves them untouched
// - QoS only in routed mode
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module qps_top
    import qps_pkg::*;
#(
    parameter int NRULE = 64,
    parameter int NSUB  = 4,
    parameter int TXMAX = 8
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire qps_pkt_s    in_pkt,
    output logic             byp_valid,
    input  wire logic        byp_ready,
    output qps_pkt_s         byp_pkt,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output qps_pkt_s         tx_pkt
);
    localparam int SW = $clog2(NSUB);
    localparam int RW = $clog2(NRULE);
    localparam int TW = $clog2(TXMAX);

    logic [3:0]   ctrl_q;
    logic [2:0]   defpri_q;
    logic [4:0]   qsize_q;
    logic [3:0]   txlen_q;
    logic [RW-1:0] rsel_q;
    qps_rule_s    rules_q [NRULE];
    qps_st_e      st_q;
    logic [RW-1:0] idx_q;
    qps_pkt_s     pkt_q;
    logic [2:0]   lvl_q;
    logic [SW-1:0] sub_q;
    qps_pkt_s     qmem_q [NLVL][NSUB][QDEP];
    logic [4:0]   wp_q [NLVL][NSUB];
    logic [4:0]   rp_q [NLVL][NSUB];
    logic [5:0]   scnt_q [NLVL][NSUB];
    logic [5:0]   lcnt_q [NLVL];
    logic [SW-1:0] rr_q [NLVL];
    qps_pkt_s     txb_q [TXMAX];
    logic [TW-1:0] twp_q;
    logic [TW-1:0] trp_q;
    logic [TW:0]  tcnt_q;

    logic         qos_act;
    logic [TW:0]  txb_depth;
    logic         txb_room;
    logic [NLVL-1:0] lvl_ne;
    logic         any_ne;
    logic [2:0]   psel_lvl;
    logic [SW-1:0] psel_sub;
    logic         q_pop;
    logic         q_push;
    logic         dir_acc;
    logic         qacc;
    logic         txb_push;
    logic         txb_pop;
    logic         cur_hit;
    logic         wr_acc;
    logic         wr_err;
    logic         rd_err;
    logic [31:0]  rd_d;
    qps_pkt_s     in_tag;

    // QoS runs only in routed mode
    assign qos_act = ctrl_q[CTRL_QOS] & ctrl_q[CTRL_RTD];

    // Prefix length to mask
    function automatic logic [31:0] pfx_mask(input logic [5:0] len);
        logic [31:0] m;
        m = '0;
        if (len >= 6'd32)
            m = 32'hFFFF_FFFF;
        else
            m = ~(32'hFFFF_FFFF >> len);
        return m;
    endfunction

    // Whole rule compare; every specified field must match
    function automatic logic rule_hit(input qps_rule_s r, input qps_pkt_s p);
        logic        ok;
        logic        tu;
        logic [7:0]  ds;
        logic [31:0] sm;
        logic [31:0] dm;
        ok = 1'b1;
        tu = (p.proto == PN_TCP) || (p.proto == PN_UDP);
        ds = p.ntp ? NTP_DS : p.ds;
        sm = pfx_mask(r.spfx) | r.smk;
        dm = pfx_mask(r.dpfx) | r.dmk;
        case (r.proto)
            PS_ICMP: ok = ok & (p.proto == PN_ICMP);
            PS_UDP:  ok = ok & (p.proto == PN_UDP);
            PS_TCP:  ok = ok & (p.proto == PN_TCP);
            PS_GRE:  ok = ok & (p.proto == PN_GRE);
            PS_ESP:  ok = ok & (p.proto == PN_ESP);
            default: ok = ok;
        endcase
        ok = ok & (((p.sip ^ r.sip) & sm) == '0);
        ok = ok & (((p.dip ^ r.dip) & dm) == '0);
        if (r.sport != '0)
            ok = ok & tu & (p.sport == r.sport);
        if (r.dport != '0)
            ok = ok & tu & (p.dport == r.dport);
        case (r.dsm)
            DS_CP:   ok = ok & (ds[7:2] == r.dsv);
            DS_PREC: ok = ok & (ds[7:5] == r.dsv[2:0]);
            default: ok = ok;
        endcase
        return ok;
    endfunction

    // Flow hash picks the fair subqueue
    function automatic logic [SW-1:0] flow_sub(input qps_pkt_s p);
        logic [31:0] h;
        h = p.sip ^ p.dip ^ {p.sport, p.dport} ^ {24'h0, p.proto};
        h = h ^ (h >> 16);
        h = h ^ (h >> 8);
        h = h ^ (h >> 4);
        return h[SW-1:0];
    endfunction

    // APB decode; CTRL rejects more than one exclusive mode
    always_comb
    begin
        wr_err = 1'b0;
        rd_err = 1'b0;
        rd_d   = '0;
        if (paddr == OFS_CTRL)
        begin
            wr_err = (32'(pwdata[0]) + 32'(pwdata[1]) + 32'(pwdata[2])) > 32'd1;
            rd_d   = {28'h0, ctrl_q};
        end
        else if (paddr == OFS_DEFPRI)
            rd_d = {29'h0, defpri_q};
        else if (paddr == OFS_QSIZE)
        begin
            wr_err = (pwdata[4:0] < QSIZE_MIN) || (pwdata[31:5] != '0);
            rd_d   = {27'h0, qsize_q};
        end
        else if (paddr == OFS_TXLEN)
        begin
            wr_err = (pwdata[3:0] == '0) || (32'(pwdata[3:0]) > TXMAX);
            rd_d   = {28'h0, txlen_q};
        end
        else if (paddr == OFS_STATUS)
        begin
            wr_err = 1'b1;
            rd_d   = {19'h0, st_q != ST_IDLE, 4'(tcnt_q), lvl_ne};
        end
        else if (paddr == OFS_RSEL)
            rd_d = 32'(rsel_q);
        else if (paddr == OFS_RSIP)
            rd_d = rules_q[rsel_q].sip;
        else if (paddr == OFS_RSMK)
            rd_d = rules_q[rsel_q].smk;
        else if (paddr == OFS_RDIP)
            rd_d = rules_q[rsel_q].dip;
        else if (paddr == OFS_RDMK)
            rd_d = rules_q[rsel_q].dmk;
        else if (paddr == OFS_RPORT)
            rd_d = {rules_q[rsel_q].sport, rules_q[rsel_q].dport};
        else if (paddr == OFS_RCFG)
            rd_d = {5'h0, rules_q[rsel_q].act, rules_q[rsel_q].prio, rules_q[rsel_q].dsv,
                    rules_q[rsel_q].dsm, rules_q[rsel_q].dpfx, rules_q[rsel_q].spfx,
                    rules_q[rsel_q].proto};
        else
        begin
            wr_err = 1'b1;
            rd_err = 1'b1;
        end
    end

    // One wait-free access; read data captured in setup
    assign pready  = 1'b1;
    // Reads fail only when unmapped; write data is not checked on reads
    assign pslverr = psel & penable & (pwrite ? wr_err : rd_err);
    assign wr_acc  = psel & penable & pwrite & ~wr_err;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (psel & ~penable & ~pwrite)
            prdata <= rd_d;
    end

    // Global settings
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q   <= '0;
            defpri_q <= DEFPRI_RST;
            qsize_q  <= QSIZE_RST;
            txlen_q  <= TXLEN_RST;
            rsel_q   <= '0;
        end
        else if (wr_acc)
        begin
            if (paddr == OFS_CTRL)
                ctrl_q <= pwdata[3:0];
            else if (paddr == OFS_DEFPRI)
                defpri_q <= pwdata[2:0];
            else if (paddr == OFS_QSIZE)
                qsize_q <= pwdata[4:0];
            else if (paddr == OFS_TXLEN)
                txlen_q <= pwdata[3:0];
            else if (paddr == OFS_RSEL)
                rsel_q <= pwdata[RW-1:0];
        end
    end

    // Rule table, reset to match-all, level 1, inactive
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NRULE; i++)
                rules_q[i] <= '0;
        end
        else if (wr_acc)
        begin
            if (paddr == OFS_RSIP)
                rules_q[rsel_q].sip <= pwdata;
            else if (paddr == OFS_RSMK)
                rules_q[rsel_q].smk <= pwdata;
            else if (paddr == OFS_RDIP)
                rules_q[rsel_q].dip <= pwdata;
            else if (paddr == OFS_RDMK)
                rules_q[rsel_q].dmk <= pwdata;
            else if (paddr == OFS_RPORT)
                {rules_q[rsel_q].sport, rules_q[rsel_q].dport} <= pwdata;
            else if (paddr == OFS_RCFG)
                {rules_q[rsel_q].act, rules_q[rsel_q].prio, rules_q[rsel_q].dsv,
                 rules_q[rsel_q].dsm, rules_q[rsel_q].dpfx, rules_q[rsel_q].spfx,
                 rules_q[rsel_q].proto} <= pwdata[26:0];
        end
    end

    // Radio-bound time-sync packets leave with their fixed DiffServ byte; bypass uses in_pkt as is
    always_comb
    begin
        in_tag = in_pkt;
        if (in_pkt.ntp)
            in_tag.ds = NTP_DS;
    end

    // Input steering; non-radio traffic bypasses untouched
    assign byp_valid = in_valid & ~in_pkt.radio;
    assign byp_pkt   = in_pkt;
    assign qacc      = in_valid & in_pkt.radio & qos_act & (st_q == ST_IDLE);
    assign dir_acc   = in_valid & in_pkt.radio & ~qos_act & ~any_ne & txb_room;
    always_comb
    begin
        if (!in_pkt.radio)
            in_ready = byp_ready;
        else if (qos_act)
            in_ready = (st_q == ST_IDLE);
        else
            in_ready = ~any_ne & txb_room;
    end

    // Classifier scan, one rule per cycle in table order
    assign cur_hit = rules_q[idx_q].act & rule_hit(rules_q[idx_q], pkt_q);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q  <= ST_IDLE;
            idx_q <= '0;
            pkt_q <= '0;
            lvl_q <= '0;
            sub_q <= '0;
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                    if (qacc)
                    begin
                        pkt_q <= in_tag;
                        sub_q <= flow_sub(in_pkt);
                        idx_q <= '0;
                        st_q  <= ST_SCAN;
                    end
                ST_SCAN:
                    if (cur_hit)
                    begin
                        lvl_q <= rules_q[idx_q].prio;
                        st_q  <= ST_PUSH;
                    end
                    else if (32'(idx_q) == NRULE - 1)
                    begin
                        lvl_q <= defpri_q;
                        st_q  <= ST_PUSH;
                    end
                    else
                        idx_q <= idx_q + 1'b1;
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    // Enqueue only below the shared level limit, else drop
    assign q_push = (st_q == ST_PUSH) && (lcnt_q[lvl_q] < 6'(qsize_q));

    // Highest non-empty level, then round-robin subqueue
    always_comb
    begin
        psel_lvl = '0;
        psel_sub = '0;
        for (int i = 0; i < NLVL; i++)
            lvl_ne[i] = lcnt_q[i] != '0;
        for (int i = NLVL - 1; i >= 0; i--)
            if (lvl_ne[i])
                psel_lvl = 3'(i);
        for (int k = NSUB - 1; k >= 0; k--)
            if (scnt_q[psel_lvl][SW'(rr_q[psel_lvl] + SW'(k))] != '0)
                psel_sub = SW'(rr_q[psel_lvl] + SW'(k));
    end
    assign any_ne = |lvl_ne;
    assign q_pop  = any_ne & txb_room;

    // Subqueue storage and pointers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int l = 0; l < NLVL; l++)
            begin
                lcnt_q[l] <= '0;
                rr_q[l]   <= '0;
                for (int s = 0; s < NSUB; s++)
                begin
                    wp_q[l][s]   <= '0;
                    rp_q[l][s]   <= '0;
                    scnt_q[l][s] <= '0;
                end
            end
        end
        else
        begin
            for (int l = 0; l < NLVL; l++)
            begin
                lcnt_q[l] <= lcnt_q[l] + 6'(q_push && lvl_q == 3'(l))
                           - 6'(q_pop && psel_lvl == 3'(l));
                for (int s = 0; s < NSUB; s++)
                    scnt_q[l][s] <= scnt_q[l][s]
                        + 6'(q_push && lvl_q == 3'(l) && sub_q == SW'(s))
                        - 6'(q_pop && psel_lvl == 3'(l) && psel_sub == SW'(s));
            end
            if (q_push)
                wp_q[lvl_q][sub_q] <= wp_q[lvl_q][sub_q] + 1'b1;
            if (q_pop)
            begin
                rp_q[psel_lvl][psel_sub] <= rp_q[psel_lvl][psel_sub] + 1'b1;
                rr_q[psel_lvl]           <= psel_sub + 1'b1;
            end
        end
    end

    // Descriptor memory, no reset
    always_ff @(posedge pclk)
    begin
        if (q_push)
            qmem_q[lvl_q][sub_q][wp_q[lvl_q][sub_q]] <= pkt_q;
    end

    // Transmit buffer, fixed to two packets under QoS
    assign txb_depth = qos_act ? (TW+1)'(QOS_TXB) : (TW+1)'(txlen_q);
    assign txb_room  = tcnt_q < txb_depth;
    assign txb_push  = q_pop | dir_acc;
    assign txb_pop   = tx_valid & tx_ready;
    assign tx_valid  = tcnt_q != '0;
    assign tx_pkt    = txb_q[trp_q];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            twp_q  <= '0;
            trp_q  <= '0;
            tcnt_q <= '0;
            for (int i = 0; i < TXMAX; i++)
                txb_q[i] <= '0;
        end
        else
        begin
            if (txb_push)
            begin
                txb_q[twp_q] <= q_pop ? qmem_q[psel_lvl][psel_sub][rp_q[psel_lvl][psel_sub]]
                                      : in_tag;
                twp_q <= (32'(twp_q) == TXMAX - 1) ? '0 : twp_q + 1'b1;
            end
            if (txb_pop)
                trp_q <= (32'(trp_q) == TXMAX - 1) ? '0 : trp_q + 1'b1;
            tcnt_q <= tcnt_q + (TW+1)'(txb_push) - (TW+1)'(txb_pop);
        end
    end

    // Checks
    logic [7:0] sum0;
    always_comb
    begin
        sum0 = '0;
        for (int s = 0; s < NSUB; s++)
            sum0 = sum0 + 8'(scnt_q[0][s]);
    end

    strict_prio_a: assert property (@(posedge pclk) disable iff (!presetn)
        q_pop |-> (lvl_ne & ((8'h01 << psel_lvl) - 8'h01)) == '0)
        else $error("lower level dispatched before higher");
    full_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_PUSH && lcnt_q[lvl_q] >= 6'(qsize_q) && !(q_pop && psel_lvl == lvl_q))
        |=> lcnt_q[$past(lvl_q)] == $past(lcnt_q[lvl_q]))
        else $error("packet stored into full level");
    txb_two_a: assert property (@(posedge pclk) disable iff (!presetn)
        (qos_act && txb_push) |-> tcnt_q < 2)
        else $error("transmit buffer above two under QoS");
    sfq_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
        sum0 == 8'(lcnt_q[0]) && lcnt_q[0] <= 6'd31)
        else $error("level count mismatch");
    def_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_SCAN && !cur_hit && 32'(idx_q) == NRULE - 1)
        |=> st_q == ST_PUSH && lvl_q == $past(defpri_q))
        else $error("default level not applied");
    first_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_SCAN && cur_hit) |=> st_q == ST_PUSH && lvl_q == $past(rules_q[idx_q].prio))
        else $error("first matching rule not used");
    mode_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
        $countones(ctrl_q[2:0]) <= 1)
        else $error("exclusive modes both enabled");
    routed_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        qacc |-> ctrl_q[CTRL_RTD] ##1 st_q == ST_SCAN)
        else $error("QoS accepted outside routed mode");
    bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
        (in_valid && !in_pkt.radio) |-> byp_valid && !qacc && !dir_acc)
        else $error("non-radio packet entered queues");

    drop_c: cover property (@(posedge pclk) disable iff (!presetn)
        st_q == ST_PUSH && !q_push);
    prio_c: cover property (@(posedge pclk) disable iff (!presetn)
        q_pop && lvl_ne[0] && lvl_ne[7]);
    direct_c: cover property (@(posedge pclk) disable iff (!presetn) dir_acc ##1 tx_valid);
endmodule
`default_nettype wire

/* sim/qos_packet_classifier_scheduler_test.sv */
// Self-checking bench for the QoS classifier and scheduler.
// Assumes qps_top on pclk, APB registers and a radio model on tx.
`timescale 1ns/1ps
`default_nettype none
module qos_packet_classifier_scheduler_test;
    import qps_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        in_valid, in_ready, byp_valid, byp_ready, tx_valid, tx_ready, stall, slow;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    qps_pkt_s    in_pkt, byp_pkt, tx_pkt, p, outq[$];
    int          err_count, n_checks, cyc, nbyp;
    integer      seed;
    logic [39:0] bad [6] = '{{OFS_QSIZE, 32'h1}, {OFS_QSIZE, 32'h20}, {OFS_CTRL, 32'h3},
                             {OFS_CTRL, 32'h6}, {OFS_STATUS, 32'h0}, {8'h30, 32'h1}};
    logic [7:0]  tags [5] = '{8'h1, 8'h2, 8'h5, 8'h4, 8'h6};

    qps_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_pkt(in_pkt),
        .byp_valid(byp_valid), .byp_ready(byp_ready), .byp_pkt(byp_pkt),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_pkt(tx_pkt));
    qps_radio_model radio (.pclk(pclk), .presetn(presetn), .stall(stall), .slow(slow),
        .tx_valid(tx_valid), .tx_pkt(tx_pkt), .tx_ready(tx_ready));

    // 40 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Capture radio and bypass traffic, cut a hang short
    always @(posedge pclk)
    begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
            outq.push_back(tx_pkt);
        if (byp_valid === 1'b1 && byp_ready === 1'b1)
            nbyp++;
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer, then an idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rule(input int i, input logic [31:0] s, input logic [5:0] pf,
                        input logic [2:0] pr, input logic [1:0] dm, input logic [5:0] dv,
                        input logic [2:0] pc, input logic a);
        apb(1'b1, OFS_RSEL, 32'(i));
        apb(1'b1, OFS_RSIP, s);
        apb(1'b1, OFS_RCFG, {5'h00, a, pc, dv, dm, 6'h00, pf, pr});
    endtask

    task automatic send(input qps_pkt_s k);
        in_pkt   <= k;
        in_valid <= 1'b1;
        @(posedge pclk);
        while (in_ready !== 1'b1)
            @(posedge pclk);
        in_valid <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    // Radio-bound packet, random low address and destination
    function automatic qps_pkt_s mk(input logic [7:0] pr, input logic [15:0] s,
                                    input logic [7:0] ds, input logic nt, input logic [7:0] tg);
        mk = '{pr, {s, 16'($random(seed))}, 32'($random(seed)), {8'h00, tg},
               16'($random(seed)), ds, nt, 1'b1};
    endfunction

    // Nonempty flag of a level code
    function automatic logic [7:0] lvl(input logic [2:0] c);
        lvl = 8'h01 << c;
    endfunction

    initial
    begin
        seed      = 32'hB16F;
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        in_valid  = 1'b0;
        in_pkt    = '0;
        byp_ready = 1'b1;
        stall     = 1'b1;
        slow      = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, then refused writes
        apb(1'b0, OFS_DEFPRI, 32'h0);
        chk("defpri", 32'h7, rd);
        foreach (bad[i])
        begin
            apb(1'b1, bad[i][39:32], bad[i][31:0]);
            chk("slverr", 32'h1, {31'h0, er});
        end
        apb(1'b0, OFS_QSIZE, 32'h0);
        chk("qsize", 32'h5, rd);
        apb(1'b0, OFS_RCFG, 32'h0);
        chk("rule rst", 32'h0, rd);
        apb(1'b0, 8'hFC, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        // Routed QoS mode with minimum queue size
        apb(1'b1, OFS_QSIZE, 32'h2);
        apb(1'b1, OFS_CTRL, 32'h9);
        chk("ctrl", 32'h0, {31'h0, er});
        rule(0, 32'h0, 6'h00, PS_ANY, DS_OFF, 6'h00, 3'h0, 1'b0);
        rule(1, 32'h0A000000, 6'h08, PS_TCP, DS_OFF, 6'h00, 3'h2, 1'b1);
        rule(2, 32'h0, 6'h00, PS_ANY, DS_CP, 6'h2E, 3'h0, 1'b1);
        rule(3, 32'h0, 6'h00, PS_ANY, DS_PREC, 6'h05, 3'h4, 1'b1);
        // Radio held off: two fill the buffer, the last is dropped at full level 8, the rest wait by level
        send(mk(PN_ICMP, 16'hC000, 8'h00, 1'b0, 8'h1));
        send(mk(PN_ICMP, 16'hC000, 8'h00, 1'b0, 8'h2));
        send(mk(PN_ICMP, 16'hC000, 8'h00, 1'b0, 8'h3));
        send(mk(PN_TCP, 16'h0A01, NTP_DS, 1'b0, 8'h4));
        send(mk(PN_UDP, 16'hC000, 8'h00, 1'b1, 8'h5));
        send(mk(PN_UDP, 16'hC000, 8'hA0, 1'b0, 8'h6));
        send(mk(PN_ICMP, 16'hC000, 8'h00, 1'b0, 8'h7));
        send(mk(PN_ICMP, 16'hC000, 8'h00, 1'b0, 8'h8));
        repeat (70) @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status", {20'h0, 4'h2, lvl(3'h7) | lvl(3'h4) | lvl(3'h2) | lvl(3'h0)}, rd);
        p = mk(PN_UDP, 16'hC000, 8'h00, 1'b0, 8'h9);
        p.radio = 1'b0;
        send(p);
        chk("bypass", 32'h1, 32'(nbyp));
        chk("byp pkt", {16'h0, p.sport}, {16'h0, byp_pkt.sport});
        // Slow drain by strict priority
        stall <= 1'b0;
        slow  <= 1'b1;
        repeat (300) @(posedge pclk);
        chk("tx count", 32'h7, 32'(outq.size()));
        for (int i = 0; i < 5; i++)
            if (i < outq.size())
                chk("tx order", {24'h0, tags[i]}, {24'h0, outq[i].sport[7:0]});
        // Two flows on level 8 may leave in either fair-share order
        if (outq.size() > 6)
            chk("tx last", 32'h0003_0007,
                (outq[5].sport < outq[6].sport) ? {outq[5].sport, outq[6].sport}
                                                : {outq[6].sport, outq[5].sport});
        if (outq.size() > 2)
            chk("sync ds", 32'hB8, {24'h0, outq[2].ds});
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("drained", 32'h0, rd);
        // QoS off: radio packets go straight to a buffer of the set length
        stall <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h8);
        repeat (4) send(mk(PN_UDP, 16'hC000, 8'h00, 1'b0, 8'hA));
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("direct", 32'h400, rd);
        chk("txb full", 32'h0, {31'h0, in_ready});
        test_done();
    end
endmodule
`default_nettype wire

/* sim/qps_radio_model.sv */
// Radio transmitter model that takes prioritised packets off the tx port.
// Assumes tx_valid and tx_pkt hold until taken on a rising pclk edge.
`timescale 1ns/1ps
`default_nettype none
module qps_radio_model
    import qps_pkg::*;
(
    input  wire logic     pclk,
    input  wire logic     presetn,
    input  wire logic     stall,
    input  wire logic     slow,
    input  wire logic     tx_valid,
    input  wire qps_pkt_s tx_pkt,
    output logic          tx_ready
);
    logic [7:0] lfsr_q;

    // Ready held off while stalled, gappy when slow
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lfsr_q   <= 8'hA5;
            tx_ready <= 1'b0;
        end
        else
        begin
            lfsr_q   <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
            tx_ready <= !stall && (!slow || lfsr_q[0]);
        end
    end
endmodule
`default_nettype wire
